// [verilog/nv_pkg.sv]
`default_nettype none
package nv_pkg;
   localparam int unsigned CELLS = 128;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PAGE_BYTES = 16;
   // register placement: sector bit plus 8-bit offset
   localparam logic ADDR_SECTOR = 1'b0;
   localparam logic DATA_SECTOR = 1'b0;
   localparam logic CTRL_SECTOR = 1'b1;
   localparam logic [7:0] ADDR_OFS = 8'h2a;
   localparam logic [7:0] DATA_OFS = 8'h2b;
   localparam logic [7:0] CTRL_OFS = 8'h40;
   // control field positions
   localparam int unsigned SEL_BIT = 7;
   localparam int unsigned WIPE_EN_BIT = 6;
   localparam int unsigned WIPE_GO_BIT = 5;
   localparam int unsigned PAGE_BIT = 4;
   localparam int unsigned PROG_EN_BIT = 3;
   localparam int unsigned PROG_GO_BIT = 2;
   localparam int unsigned FETCH_EN_BIT = 1;
   localparam int unsigned FETCH_GO_BIT = 0;
   // reset values
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // cycle times
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned WIPE_SHORT_NS = 3200000;
   localparam int unsigned PROG_SHORT_NS = 2200000;
   localparam int unsigned WIPE_LONG_NS = 3700000;
   localparam int unsigned PROG_LONG_NS = 3000000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WIPE = 2'b01,
      ST_PROG = 2'b10,
      ST_FETCH = 2'b11
   } op_e;
   typedef struct packed {
      logic wr;
      logic rd;
      logic sector;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;
endpackage : nv_pkg
`default_nettype wire

// [verilog/eeprom_data_access_regs.sv]
// Summary of operation
// - store holds 128 bytes, reachable only through the registers here.
// - one byte, or the tagged bytes of one 16-byte page for page-mode erase and write, per operation via address, data and control registers.
// - address and data registers sit in sector 0, directly accessed.
// - address register keeps 7 bits, bit 7 reads zero, resets zero.
// - data register keeps 8 bits, resets zero.
// - select bit zero gives erase 3.2 ms, write 2.2 ms.
// - select bit one gives erase 3.7 ms, write 3.0 ms.
// - writing one to erase trigger starts an erase cycle.
// - erase trigger clears itself when the erase ends.
// - erase trigger ignored unless erase enable already set.
// - mode bit picks byte or 16-byte page operation.
// - write trigger needs write enable, clears itself at the end.
// - read trigger needs read enable, clears itself at the end.
// - erase enable clears itself when an erase ends.
`timescale 1ns/1ps
`default_nettype none
module eeprom_data_access_regs
   import nv_pkg::*;
#(
   parameter int unsigned WIPE_SHORT_CYC = WIPE_SHORT_NS / CLK_NS,
   parameter int unsigned PROG_SHORT_CYC = PROG_SHORT_NS / CLK_NS,
   parameter int unsigned WIPE_LONG_CYC = WIPE_LONG_NS / CLK_NS,
   parameter int unsigned PROG_LONG_CYC = PROG_LONG_NS / CLK_NS,
   parameter int unsigned CNT_W = 17
) (
   input wire logic clk,
   input wire logic srst,
   input wire nv_pkg::sfr_req_s sfr,
   output logic [7:0] rdata_q,
   output logic busy
);
   import nv_pkg::*;

   logic [DATA_W-1:0] mem [CELLS];
   logic [DATA_W-1:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] tag_q;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] data_q, data_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   op_e st_q, st_d;

   function automatic logic [ADDR_W-1:0] nib_inc(
      input logic [ADDR_W-1:0] a
   );
      // page pointer stops at the last byte, never rolls into next page
      nib_inc = (a[3:0] == 4'hf) ? a : {a[ADDR_W-1:4], a[3:0] + 4'h1};
   endfunction : nib_inc

   function automatic logic hit(input sfr_req_s r, input logic sec,
                                input logic [7:0] ofs);
      hit = (r.sector == sec) && (r.addr == ofs);
   endfunction : hit

   wire addr_wr = sfr.wr && hit(sfr, ADDR_SECTOR, ADDR_OFS);
   wire data_wr = sfr.wr && hit(sfr, DATA_SECTOR, DATA_OFS);
   wire ctrl_wr = sfr.wr && hit(sfr, CTRL_SECTOR, CTRL_OFS);
   wire idle = (st_q == ST_IDLE);
   wire page_mode = ctrl_q[PAGE_BIT];
   wire long_sel = ctrl_q[SEL_BIT];
   // enables are checked as already stored, not as written now
   wire go_wipe = ctrl_wr && sfr.wdata[WIPE_GO_BIT]
                  && ctrl_q[WIPE_EN_BIT] && idle;
   wire go_prog = ctrl_wr && sfr.wdata[PROG_GO_BIT]
                  && ctrl_q[PROG_EN_BIT] && idle && !go_wipe;
   wire go_fetch = ctrl_wr && sfr.wdata[FETCH_GO_BIT]
                   && ctrl_q[FETCH_EN_BIT] && idle
                   && !go_wipe && !go_prog;
   wire timed = (st_q == ST_WIPE) || (st_q == ST_PROG);
   wire expire = timed && (cnt_q == '0);
   wire wipe_done = expire && (st_q == ST_WIPE);
   wire prog_done = expire && (st_q == ST_PROG);
   wire fetch_done = (st_q == ST_FETCH);
   wire buf_load = data_wr && idle && page_mode;
   wire [DATA_W-1:0] fetch_byte = mem[addr_q];
   wire [CNT_W-1:0] wipe_len = long_sel ? CNT_W'(WIPE_LONG_CYC - 1)
                                        : CNT_W'(WIPE_SHORT_CYC - 1);
   wire [CNT_W-1:0] prog_len = long_sel ? CNT_W'(PROG_LONG_CYC - 1)
                                        : CNT_W'(PROG_SHORT_CYC - 1);
   wire [7:0] rd_mux = hit(sfr, ADDR_SECTOR, ADDR_OFS) ? {1'b0, addr_q}
                     : hit(sfr, DATA_SECTOR, DATA_OFS) ? data_q
                     : hit(sfr, CTRL_SECTOR, CTRL_OFS) ? ctrl_q
                     : 8'h00;
   wire wipe_en_fall = ctrl_q[WIPE_EN_BIT] && !ctrl_d[WIPE_EN_BIT];

   assign busy = !idle;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         ST_IDLE: begin
            if (go_wipe) begin
               st_d = ST_WIPE;
               cnt_d = wipe_len;
            end else if (go_prog) begin
               st_d = ST_PROG;
               cnt_d = prog_len;
            end else if (go_fetch) begin
               st_d = ST_FETCH;
            end
         end
         ST_WIPE, ST_PROG: begin
            if (expire) begin
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ST_FETCH: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_comb begin
      ctrl_d = ctrl_q;
      if (wipe_done) begin
         ctrl_d[WIPE_GO_BIT] = 1'b0;
         ctrl_d[WIPE_EN_BIT] = 1'b0;
      end
      if (prog_done) begin
         ctrl_d[PROG_GO_BIT] = 1'b0;
      end
      if (fetch_done) begin
         ctrl_d[FETCH_GO_BIT] = 1'b0;
      end
      // software write lands after hardware clears, so a set is not lost
      if (ctrl_wr) begin
         ctrl_d[SEL_BIT] = sfr.wdata[SEL_BIT];
         ctrl_d[WIPE_EN_BIT] = sfr.wdata[WIPE_EN_BIT];
         ctrl_d[PAGE_BIT] = sfr.wdata[PAGE_BIT];
         ctrl_d[PROG_EN_BIT] = sfr.wdata[PROG_EN_BIT];
         ctrl_d[FETCH_EN_BIT] = sfr.wdata[FETCH_EN_BIT];
      end
      if (go_wipe) begin
         ctrl_d[WIPE_GO_BIT] = 1'b1;
      end
      if (go_prog) begin
         ctrl_d[PROG_GO_BIT] = 1'b1;
      end
      if (go_fetch) begin
         ctrl_d[FETCH_GO_BIT] = 1'b1;
      end
   end

   always_comb begin
      addr_d = addr_q;
      data_d = data_q;
      if (addr_wr) begin
         addr_d = sfr.wdata[ADDR_W-1:0];
      end
      if (data_wr) begin
         data_d = sfr.wdata;
      end
      if (buf_load) begin
         addr_d = nib_inc(addr_q);
      end
      if (fetch_done) begin
         data_d = fetch_byte;
         if (page_mode) begin
            addr_d = nib_inc(addr_q);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         ctrl_q <= CTRL_RST;
         addr_q <= ADDR_RST;
         data_q <= DATA_RST;
         rdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         data_q <= data_d;
         rdata_q <= sfr.rd ? rd_mux : rdata_q;
      end
   end

   // page buffer tags mark which bytes a page operation touches
   always_ff @(posedge clk) begin
      if (srst) begin
         tag_q <= '0;
      end else if (wipe_en_fall || wipe_done || prog_done) begin
         tag_q <= '0;
      end else if (buf_load) begin
         tag_q[addr_q[3:0]] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (buf_load) begin
         page_buf[addr_q[3:0]] <= sfr.wdata;
      end
   end

   // store contents survive reset on purpose: it is the nonvolatile array
   always_ff @(posedge clk) begin
      if (!srst && (wipe_done || prog_done)) begin
         if (page_mode) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
               if (tag_q[i]) begin
                  mem[{addr_q[ADDR_W-1:4], 4'(i)}] <=
                     wipe_done ? 8'h00 : page_buf[i];
               end
            end
         end else begin
            mem[addr_q] <= wipe_done ? 8'h00 : data_q;
         end
      end
   end

   ignore_trig_a: assert property (@(posedge clk) disable iff (srst)
      ctrl_wr && sfr.wdata[WIPE_GO_BIT] && !ctrl_q[WIPE_EN_BIT]
      && idle && !sfr.wdata[PROG_GO_BIT] && !sfr.wdata[FETCH_GO_BIT]
      |=> st_q == ST_IDLE && !ctrl_q[WIPE_GO_BIT])
      else $error("erase started without enable");
   wipe_end_a: assert property (@(posedge clk) disable iff (srst)
      wipe_done |=> !ctrl_q[WIPE_GO_BIT] && idle
      && (!ctrl_q[WIPE_EN_BIT] || $past(ctrl_wr)))
      else $error("erase end left bits set");
   wipe_len_a: assert property (@(posedge clk) disable iff (srst)
      go_wipe |=> st_q == ST_WIPE && cnt_q == $past(wipe_len)
      && ctrl_q[WIPE_GO_BIT])
      else $error("erase duration wrong");
   short_time_a: assert property (@(posedge clk) disable iff (srst)
      go_prog && !long_sel |=> cnt_q == CNT_W'(PROG_SHORT_CYC - 1))
      else $error("short write time wrong");
   long_time_a: assert property (@(posedge clk) disable iff (srst)
      go_wipe && long_sel |=> cnt_q == CNT_W'(WIPE_LONG_CYC - 1))
      else $error("long erase time wrong");
   timer_count_a: assert property (@(posedge clk) disable iff (srst)
      timed && cnt_q != '0 |=> cnt_q == $past(cnt_q) - CNT_W'(1)
      && st_q == $past(st_q))
      else $error("cycle timer not counting");
   fetch_data_a: assert property (@(posedge clk) disable iff (srst)
      go_fetch |=> ctrl_q[FETCH_GO_BIT] ##1
      (!ctrl_q[FETCH_GO_BIT] && data_q == $past(fetch_byte)))
      else $error("read did not deliver");
   prog_byte_a: assert property (@(posedge clk) disable iff (srst)
      prog_done && !page_mode |=> mem[$past(addr_q)] == $past(data_q)
      && !ctrl_q[PROG_GO_BIT])
      else $error("byte write lost");
   page_stop_a: assert property (@(posedge clk) disable iff (srst)
      fetch_done && page_mode && !addr_wr && addr_q[3:0] == 4'hf
      |=> addr_q == $past(addr_q))
      else $error("page pointer rolled over");
   addr_top_a: assert property (@(posedge clk) disable iff (srst)
      sfr.rd && hit(sfr, ADDR_SECTOR, ADDR_OFS)
      |=> !rdata_q[7] && rdata_q[6:0] == $past(addr_q))
      else $error("address readback wrong");
   data_rb_a: assert property (@(posedge clk) disable iff (srst)
      data_wr && !fetch_done ##1 !data_wr && !fetch_done
      ##1 sfr.rd && hit(sfr, DATA_SECTOR, DATA_OFS)
      |=> rdata_q == $past(sfr.wdata, 3))
      else $error("data readback wrong");
endmodule : eeprom_data_access_regs
`default_nettype wire

// [tb/test_eeprom_data_access_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_data_access_regs;
   import nv_pkg::*;
   // short cycle counts keep the run brief; all expectations use these
   localparam int WS = 20;
   localparam int PS = 10;
   localparam int WL = 30;
   localparam int PL = 25;
   logic clk = 1'b0;
   logic srst = 1'b1;
   sfr_req_s sfr = '0;
   logic [7:0] rdata_q;
   logic busy;
   int failures = 0;
   int checked = 0;
   int seed = 32'h3ad499a2;
   int mem_m [CELLS];
   int addr_m = 0;
   int data_m = 0;
   int ctrl_m = 0;
   int a, a2, d;

   eeprom_data_access_regs #(.WIPE_SHORT_CYC(WS), .PROG_SHORT_CYC(PS),
      .WIPE_LONG_CYC(WL), .PROG_LONG_CYC(PL)) eeprom_data_access_regs_inst (
      .clk(clk), .srst(srst), .sfr(sfr), .rdata_q(rdata_q), .busy(busy));

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic stop_test;
      if (failures == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk_byte(input string what, input logic [7:0] exp,
                           input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk_byte

   task automatic chk_cyc(input string what, input int exp, input int seen);
      checked++;
      if (seen != exp) begin
         failures++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : chk_cyc

   // one request cycle, released on the edge that takes it
   task automatic bus(input logic w, input logic s, input logic [7:0] ofs,
                      input logic [7:0] wd);
      @(posedge clk);
      sfr <= '{wr: w, rd: !w, sector: s, addr: ofs, wdata: wd};
      @(posedge clk);
      sfr <= '0;
      #1;
   endtask : bus

   task automatic rd_reg(input string what, input logic s,
                         input logic [7:0] ofs, input int v);
      bus(1'b0, s, ofs, 8'h00);
      chk_byte(what, v[7:0], rdata_q);
   endtask : rd_reg

   task automatic put_addr(input int v);
      bus(1'b1, ADDR_SECTOR, ADDR_OFS, v[7:0]);
      addr_m = v & 8'h7f;
   endtask : put_addr

   // byte mode only: in page mode a data write would also tag and step
   task automatic put_data(input int v);
      bus(1'b1, DATA_SECTOR, DATA_OFS, v[7:0]);
      data_m = v & 8'hff;
   endtask : put_data

   // triggers latch only when their enable was already stored
   function automatic int ctrl_next(input int old, input int v);
      int n;
      n = v & 8'hda;
      if ((v & 8'h20) && (old & 8'h40)) n = n | 8'h20;
      else if ((v & 8'h04) && (old & 8'h08)) n = n | 8'h04;
      else if ((v & 8'h01) && (old & 8'h02)) n = n | 8'h01;
      return n;
   endfunction : ctrl_next

   // control write, then measure the busy span against the model
   task automatic go(input int v);
      int n;
      int len;
      ctrl_m = ctrl_next(ctrl_m, v);
      bus(1'b1, CTRL_SECTOR, CTRL_OFS, v[7:0]);
      len = ctrl_m[5] ? (ctrl_m[7] ? WL : WS) :
            ctrl_m[2] ? (ctrl_m[7] ? PL : PS) : ctrl_m[0] ? 1 : 0;
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_cyc("busy cycles", len, n);
      if (ctrl_m[5]) begin
         mem_m[addr_m] = 0;
         ctrl_m = ctrl_m & 8'h9f;
      end
      if (ctrl_m[2]) begin
         mem_m[addr_m] = data_m;
         ctrl_m = ctrl_m & 8'hfb;
      end
      if (ctrl_m[0]) begin
         data_m = mem_m[addr_m];
         ctrl_m = ctrl_m & 8'hfe;
         if (ctrl_m[4] && (addr_m & 15) != 15) addr_m++;
      end
   endtask : go

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      stop_test;
   end

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_reg("address", ADDR_SECTOR, ADDR_OFS, 0);
      rd_reg("data", DATA_SECTOR, DATA_OFS, 0);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, 0);
      rd_reg("unmapped", CTRL_SECTOR, ADDR_OFS, 0);
      put_addr(8'hff);
      rd_reg("address", ADDR_SECTOR, ADDR_OFS, 8'h7f);
      d = $random(seed) & 8'hff;
      put_data(d);
      rd_reg("data", DATA_SECTOR, DATA_OFS, d);
      go(8'h20);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, ctrl_m);
      a = ($random(seed) & 8'h70) | 8'h03;
      a2 = (a ^ 8'h10) | 8'h0e;
      put_addr(a);
      d = $random(seed) & 8'hff;
      put_data(d);
      go(8'h08);
      go(8'h0c);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, ctrl_m);
      put_data(~d);
      go(8'h02);
      go(8'h03);
      rd_reg("data", DATA_SECTOR, DATA_OFS, data_m);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, ctrl_m);
      put_addr(a2);
      put_data($random(seed));
      go(8'h88);
      go(8'h8c);
      put_addr(a);
      go(8'h40);
      go(8'h60);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, ctrl_m);
      go(8'h02);
      go(8'h03);
      rd_reg("data", DATA_SECTOR, DATA_OFS, data_m);
      put_addr(a2);
      go(8'hc0);
      go(8'he0);
      rd_reg("control", CTRL_SECTOR, CTRL_OFS, ctrl_m);
      go(8'h12);
      go(8'h13);
      rd_reg("data", DATA_SECTOR, DATA_OFS, data_m);
      rd_reg("address", ADDR_SECTOR, ADDR_OFS, addr_m);
      // page program: two tagged bytes, pointer saturates at the top
      a = (a & 8'h70) | 8'h0e;
      put_addr(a);
      go(8'h18);
      bus(1'b1, DATA_SECTOR, DATA_OFS, d[7:0]);
      bus(1'b1, DATA_SECTOR, DATA_OFS, ~d[7:0]);
      mem_m[a] = d & 8'hff;
      addr_m = a | 1;
      data_m = ~d & 8'hff;
      go(8'h1c);
      rd_reg("address", ADDR_SECTOR, ADDR_OFS, addr_m);
      go(8'h02);
      put_addr(a);
      go(8'h03);
      rd_reg("data", DATA_SECTOR, DATA_OFS, data_m);
      stop_test;
   end
endmodule : test_eeprom_data_access_regs
`default_nettype wire
